// ==== inc/analog_power_defines.svh ====
// Contract
// R01 - software writes zero to reserved bits [7:4] and bit 0 of power control
// R02 - power code 00 powers ADC only on a trigger; 01 and 10 are reserved
// R03 - on-demand mode waits the ADC wake-up delay before the conversion starts
// R04 - code 11 keeps the ADC powered continuously in Normal or Halt
// R05 - code 11 keeps the reference buffer powered when it is the positive reference
// R06 - code 11 makes the wake-up delay zero; conversion starts at once
// R07 - DAC is powered while the DAC enable bit is one, off otherwise
`ifndef ANALOG_POWER_DEFINES_SVH
`define ANALOG_POWER_DEFINES_SVH

// register indices; byte address is four times the index
`define PWR_CTRL_INDEX 14'h0f81
`define PWR_STAT_INDEX 14'h0f82
`define PWR_CTRL_RESET 8'h00

// power control fields
`define PWR_ADC_MSB 3
`define PWR_ADC_LSB 2
`define PWR_DAC_BIT 1

// status fields
`define STAT_STATE_MSB 1
`define STAT_STATE_LSB 0
`define STAT_ADC_BIT 2
`define STAT_VREF_BIT 3
`define STAT_DAC_BIT 4
`define STAT_MISS_BIT 5
`define STAT_COUNT_MSB 15
`define STAT_COUNT_LSB 8

// adc wake-up time
`define CLK_MHZ 125
`define ADC_WAKE_NS 1000
`define ADC_WAKE_CYC ((`ADC_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_CNT_W 8

`endif

// ==== inc/analog_power_pkg.sv ====
package analog_power_pkg;

    typedef enum logic [1:0] {
        ADC_PWR_ON_DEMAND = 2'b00,
        ADC_PWR_RSVD_1 = 2'b01,
        ADC_PWR_RSVD_2 = 2'b10,
        ADC_PWR_CONTINUOUS = 2'b11
    } adc_pwr_mode_t;

    typedef enum logic [1:0] {
        OP_NORMAL = 2'b00,
        OP_HALT = 2'b01,
        OP_STOP = 2'b10
    } op_mode_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAKE = 2'b01,
        SEQ_CONV = 2'b11
    } seq_state_t;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10,
        RESP_DECERR = 2'b11
    } axi_resp_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_full;
        logic w_full;
        logic [15:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        axi_resp_t bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        axi_resp_t rresp;
    } bus_state_t;

    typedef struct packed {
        adc_pwr_mode_t adc_mode;
        logic dac_en;
    } ctrl_reg_t;

    typedef struct packed {
        bus_state_t bus;
        ctrl_reg_t ctrl;
        seq_state_t seq;
        logic [7:0] wake_cnt;
        logic miss;
        logic [7:0] conv_count;
        logic adc_power;
        logic vref_power;
        logic dac_power;
        logic conv_start;
    } state_t;

endpackage

// ==== verilog/analog_power_enable_reg.sv ====
`timescale 1ns/10ps
`include "analog_power_defines.svh"

module analog_power_enable_reg
    import analog_power_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] op_mode,
    input wire logic vref_buf_selected,
    input wire logic adc_trigger,
    input wire logic adc_conv_done,
    output logic adc_power_en,
    output logic adc_vref_buf_en,
    output logic adc_conv_start,
    output logic dac_power_en
);

    localparam logic [7:0] WAKE_LAST = 8'(`ADC_WAKE_CYC - 1);

    state_t st_r;
    state_t st_nxt;

    logic running;
    logic continuous;
    logic wr_fire;
    logic rd_fire;
    logic [13:0] wr_index;
    logic [13:0] rd_index;
    logic miss_clear;
    logic miss_set;
    logic [31:0] status_word;

    assign running = (op_mode == OP_NORMAL) || (op_mode == OP_HALT);
    assign continuous = (st_r.ctrl.adc_mode == ADC_PWR_CONTINUOUS) && running; // R04
    assign wr_fire = st_r.bus.aw_full && st_r.bus.w_full && !st_r.bus.bvalid;
    assign rd_fire = s_axi_arvalid && st_r.bus.arready;
    assign wr_index = st_r.bus.aw_addr[15:2];
    assign rd_index = s_axi_araddr[15:2];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STAT_STATE_MSB:`STAT_STATE_LSB] = st_r.seq;
        status_word[`STAT_ADC_BIT] = st_r.adc_power;
        status_word[`STAT_VREF_BIT] = st_r.vref_power;
        status_word[`STAT_DAC_BIT] = st_r.dac_power;
        status_word[`STAT_MISS_BIT] = st_r.miss;
        status_word[`STAT_COUNT_MSB:`STAT_COUNT_LSB] = st_r.conv_count;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.conv_start = 1'b0;
        miss_clear = 1'b0;
        miss_set = 1'b0;

        // write address and data are taken independently
        if (s_axi_awvalid && st_r.bus.awready) begin
            st_nxt.bus.aw_addr = s_axi_awaddr;
            st_nxt.bus.aw_full = 1'b1;
            st_nxt.bus.awready = 1'b0;
        end
        if (s_axi_wvalid && st_r.bus.wready) begin
            st_nxt.bus.w_data = s_axi_wdata;
            st_nxt.bus.w_strb = s_axi_wstrb;
            st_nxt.bus.w_full = 1'b1;
            st_nxt.bus.wready = 1'b0;
        end

        if (wr_fire) begin
            st_nxt.bus.aw_full = 1'b0;
            st_nxt.bus.w_full = 1'b0;
            st_nxt.bus.bvalid = 1'b1;
            st_nxt.bus.bresp = RESP_OKAY;
            if (wr_index == `PWR_CTRL_INDEX) begin
                // reserved bits are not stored and read back as zero
                if (st_r.bus.w_strb[0]) begin
                    st_nxt.ctrl.adc_mode =
                        adc_pwr_mode_t'(st_r.bus.w_data[`PWR_ADC_MSB:`PWR_ADC_LSB]);
                    st_nxt.ctrl.dac_en = st_r.bus.w_data[`PWR_DAC_BIT];
                end
            end else if (wr_index == `PWR_STAT_INDEX) begin
                // missed-trigger flag is write-one-to-clear
                miss_clear = st_r.bus.w_strb[0] && st_r.bus.w_data[`STAT_MISS_BIT];
            end else begin
                st_nxt.bus.bresp = RESP_DECERR;
            end
        end

        if (st_r.bus.bvalid && s_axi_bready) begin
            st_nxt.bus.bvalid = 1'b0;
            st_nxt.bus.awready = 1'b1;
            st_nxt.bus.wready = 1'b1;
        end

        if (rd_fire) begin
            st_nxt.bus.arready = 1'b0;
            st_nxt.bus.rvalid = 1'b1;
            st_nxt.bus.rresp = RESP_OKAY;
            if (rd_index == `PWR_CTRL_INDEX) begin
                st_nxt.bus.rdata = 32'h0000_0000;
                st_nxt.bus.rdata[`PWR_ADC_MSB:`PWR_ADC_LSB] = st_r.ctrl.adc_mode;
                st_nxt.bus.rdata[`PWR_DAC_BIT] = st_r.ctrl.dac_en;
            end else if (rd_index == `PWR_STAT_INDEX) begin
                st_nxt.bus.rdata = status_word;
            end else begin
                st_nxt.bus.rdata = 32'h0000_0000;
                st_nxt.bus.rresp = RESP_DECERR;
            end
        end
        if (st_r.bus.rvalid && s_axi_rready) begin
            st_nxt.bus.rvalid = 1'b0;
            st_nxt.bus.arready = 1'b1;
        end

        // conversion power sequencer
        unique case (st_r.seq)
            SEQ_IDLE: begin
                if (adc_trigger && running) begin
                    if (continuous) begin
                        st_nxt.seq = SEQ_CONV; // R06
                        st_nxt.conv_start = 1'b1; // R06
                    end else begin
                        // reserved codes behave as on-demand
                        st_nxt.seq = SEQ_WAKE; // R02
                        st_nxt.wake_cnt = WAKE_LAST; // R03
                    end
                end else if (adc_trigger) begin
                    miss_set = 1'b1;
                end
            end
            SEQ_WAKE: begin
                if (adc_trigger) begin
                    miss_set = 1'b1;
                end
                if (st_r.wake_cnt == 8'h00) begin
                    st_nxt.seq = SEQ_CONV; // R03
                    st_nxt.conv_start = 1'b1; // R03
                end else begin
                    st_nxt.wake_cnt = st_r.wake_cnt - 8'h01; // R03
                end
            end
            SEQ_CONV: begin
                if (adc_trigger) begin
                    miss_set = 1'b1;
                end
                if (adc_conv_done) begin
                    st_nxt.seq = SEQ_IDLE;
                    st_nxt.conv_count = st_r.conv_count + 8'h01;
                end
            end
        endcase

        // a new miss in the clearing cycle is kept
        if (miss_set) begin
            st_nxt.miss = 1'b1;
        end else if (miss_clear) begin
            st_nxt.miss = 1'b0;
        end

        st_nxt.adc_power = continuous || (st_nxt.seq != SEQ_IDLE); // R02 R04
        st_nxt.vref_power = st_nxt.adc_power && vref_buf_selected; // R05
        st_nxt.dac_power = st_nxt.ctrl.dac_en; // R07
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.bus.awready <= 1'b1;
            st_r.bus.wready <= 1'b1;
            st_r.bus.arready <= 1'b1;
            st_r.ctrl <= ctrl_reg_t'(3'(`PWR_CTRL_RESET >> 1));
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.bus.awready;
    assign s_axi_wready = st_r.bus.wready;
    assign s_axi_bvalid = st_r.bus.bvalid;
    assign s_axi_bresp = st_r.bus.bresp;
    assign s_axi_arready = st_r.bus.arready;
    assign s_axi_rvalid = st_r.bus.rvalid;
    assign s_axi_rdata = st_r.bus.rdata;
    assign s_axi_rresp = st_r.bus.rresp;
    assign adc_power_en = st_r.adc_power;
    assign adc_vref_buf_en = st_r.vref_power;
    assign adc_conv_start = st_r.conv_start;
    assign dac_power_en = st_r.dac_power;

endmodule // analog_power_enable_reg

// ==== dv/analog_power_monitor.sv ====
`timescale 1ns/10ps
`include "analog_power_defines.svh"
module analog_power_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] op_mode,
    input wire logic vref_buf_selected,
    input wire logic adc_trigger,
    input wire logic s_axi_bvalid,
    input wire logic adc_power_en,
    input wire logic adc_vref_buf_en,
    input wire logic adc_conv_start,
    input wire logic dac_power_en
);
    localparam int WAKE = `ADC_WAKE_CYC;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // power raised by an accepted trigger, mode not moving
    sequence s_woke;
        $rose(adc_power_en) && $past(adc_trigger) && $stable(op_mode);
    endsequence
    property p_wake_start;
        s_woke |-> ##WAKE adc_conv_start;
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("start off wake time");
    property p_wake_quiet;
        s_woke |-> !adc_conv_start [*8];
    endproperty
    a_wake_quiet: assert property (p_wake_quiet) else $error("start during wake");
    property p_zero_wake;
        adc_conv_start && $past(adc_trigger) |-> $past(adc_power_en);
    endproperty
    a_zero_wake: assert property (p_zero_wake) else $error("early start unpowered");
    property p_stop_off;
        op_mode[1] [*2] |-> !adc_power_en && !adc_vref_buf_en;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("power in stop");
    property p_vref_gate;
        adc_vref_buf_en |-> adc_power_en && $past(vref_buf_selected);
    endproperty
    a_vref_gate: assert property (p_vref_gate) else $error("vref buffer ungated");
    property p_dac_write;
        $changed(dac_power_en) && op_mode == $past(op_mode, 2) |->
            s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_dac_write: assert property (p_dac_write) else $error("dac moved without write");
    c_conv: cover property (adc_conv_start);
    c_dac: cover property ($rose(dac_power_en));
    c_vref: cover property ($rose(adc_vref_buf_en));
endmodule // analog_power_monitor

bind analog_power_enable_reg analog_power_monitor mon_u (.*);

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`include "analog_power_defines.svh"
module testbench
    import analog_power_pkg::*;
;
    localparam logic [15:0] CA = {`PWR_CTRL_INDEX, 2'b00};
    localparam logic [15:0] SA = {`PWR_STAT_INDEX, 2'b00};
    logic aclk = 0;
    logic aresetn = 0;
    logic [15:0] s_axi_awaddr = '0;
    logic [15:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = '0;
    logic [2:0] s_axi_arprot = '0;
    logic s_axi_awvalid = 0;
    logic s_axi_wvalid = 0;
    logic s_axi_bready = 0;
    logic s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [1:0] op_mode = '0;
    logic vref_buf_selected = 0;
    logic adc_trigger = 0;
    logic adc_conv_done = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire adc_power_en, adc_vref_buf_en, adc_conv_start, dac_power_en;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] rd_v;
    logic [1:0] rs;

    analog_power_enable_reg dut_u (.*);

    always #4 aclk = ~aclk;

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    task rd(input logic [15:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        rd_v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    // one-cycle pulse on trigger or on conversion done
    task trig(input bit done);
        @(posedge aclk);
        if (done) adc_conv_done <= 1;
        else adc_trigger <= 1;
        @(posedge aclk);
        adc_trigger <= 0;
        adc_conv_done <= 0;
    endtask

    task step(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task t_cont;
        rd(CA);
        chk("ctrl", 32'h0000_0000, rd_v);
        vref_buf_selected <= 1;
        wr(CA, 8'h0e);
        rd(CA);
        chk("ctrl", 32'h0000_000e, rd_v);
        step(2);
        chk("adc", 1, adc_power_en);
        chk("vref", 1, adc_vref_buf_en);
        chk("dac", 1, dac_power_en);
        trig(0);
        step(0);
        chk("start", 1, adc_conv_start);
        trig(1);
        vref_buf_selected <= 0;
        step(2);
        chk("vref", 0, adc_vref_buf_en);
        chk("adc", 1, adc_power_en);
        @(posedge aclk) op_mode <= 2'b10;
        step(2);
        chk("adc", 0, adc_power_en);
        trig(0);
        step(0);
        chk("start", 0, adc_conv_start);
        @(posedge aclk) op_mode <= 2'b01;
        step(2);
        chk("adc", 1, adc_power_en);
    endtask

    task t_demand;
        vref_buf_selected <= 1;
        wr(CA, 8'h00);
        step(2);
        chk("dac", 0, dac_power_en);
        chk("adc", 0, adc_power_en);
        trig(0);
        step(1);
        chk("adc", 1, adc_power_en);
        chk("vref", 1, adc_vref_buf_en);
        step(`ADC_WAKE_CYC - 2);
        chk("start", 0, adc_conv_start);
        step(1);
        chk("start", 1, adc_conv_start);
        trig(1);
        step(1);
        chk("adc", 0, adc_power_en);
    endtask

    task t_resv;
        for (int i = 1; i < 3; i++) begin
            wr(CA, 8'(i << 2));
            rd(CA);
            chk("ctrl", 32'(i << 2), rd_v);
            step(0);
            chk("adc", 0, adc_power_en);
        end
        wr(16'h0000, 8'h0e);
        chk("bresp", RESP_DECERR, rs);
        rd(16'h0000);
        chk("rresp", RESP_DECERR, rs);
        chk("rdata", 32'h0000_0000, rd_v);
        // two finished conversions and the trigger missed in stop
        rd(SA);
        chk("status", 32'h0000_0220, rd_v);
        wr(SA, 8'h20);
        rd(SA);
        chk("status", 32'h0000_0200, rd_v);
    endtask

    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        t_cont;
        t_demand;
        t_resv;
        tally_and_finish;
    end

    initial begin
        #20000;
        err_count++;
        tally_and_finish;
    end
endmodule // testbench
